// *** verilog/wcb_defines.svh ***
`ifndef WCB_DEFINES_SVH
`define WCB_DEFINES_SVH

`define WCB_ADDR_W        32
`define WCB_LINE_BYTES    64
`define WCB_OFS_W         6
`define WCB_TAG_W         26
`define WCB_CHUNK_BYTES   8
`define WCB_CHUNKS        8
`define WCB_CHUNK_W       3
`define WCB_CNT_W         4
`define WCB_NUM_LINES     4
`define WCB_IDX_W         2
`define WCB_PAGE_SHIFT    12
`define WCB_PAGE_W        20
`define WCB_MAX_PARTIALS  4'h8
`define WCB_FULL_BE       8'hFF

`endif

// *** verilog/wcb_pkg.sv ***
`include "wcb_defines.svh"

package wcb_pkg;

  typedef enum logic [1:0] {
    write_back_type,
    write_combining_type,
    strong_uncacheable_type,
    other_type
  } mem_type_e;

  typedef enum logic [1:0] {
    s_idle,
    s_burst,
    s_part
  } fsm_e;

  typedef logic [`WCB_CHUNKS-1:0][`WCB_CHUNK_BYTES-1:0] mask_t;

  typedef struct packed {
    logic [`WCB_TAG_W-1:0]                     tag;
    mask_t                                     mask;
    logic [`WCB_CHUNKS-1:0][8*`WCB_CHUNK_BYTES-1:0] data;
  } line_s;

  typedef struct packed {
    fsm_e                        fsm;
    logic [`WCB_IDX_W-1:0]       ev_idx;
    logic [`WCB_IDX_W-1:0]       alloc_ptr;
    logic [`WCB_CNT_W-1:0]       chunk;
    logic [`WCB_CNT_W-1:0]       part_cnt;
    logic                        drain;
    logic                        o_valid;
    logic                        o_burst;
    logic                        o_last;
    logic [`WCB_ADDR_W-1:0]      o_addr;
    logic [8*`WCB_CHUNK_BYTES-1:0] o_data;
    logic [`WCB_CHUNK_BYTES-1:0] o_be;
    logic [`WCB_TAG_W-1:0]       code_line;
    logic                        code_line_v;
  } core_s;

endpackage

// *** verilog/lb_if.sv ***
`include "wcb_defines.svh"

interface lb_if;
  logic                          wr;
  logic                          alloc;
  logic                          clr;
  logic [`WCB_TAG_W-1:0]         tag_in;
  logic [`WCB_CHUNK_W-1:0]       chunk;
  logic [`WCB_CHUNK_W-1:0]       rd_chunk;
  logic [8*`WCB_CHUNK_BYTES-1:0] wdata;
  logic [`WCB_CHUNK_BYTES-1:0]   be;
  logic [`WCB_TAG_W-1:0]         tag;
  logic [8*`WCB_CHUNK_BYTES-1:0] rdata;
  wcb_pkg::mask_t                mask;
  logic                          used;
  logic                          full;

  modport ctrl (output wr, alloc, clr, tag_in, chunk, rd_chunk, wdata, be,
                input  tag, rdata, mask, used, full);
  modport line (input  wr, alloc, clr, tag_in, chunk, rd_chunk, wdata, be,
                output tag, rdata, mask, used, full);
endinterface

// *** verilog/line_buffer.sv ***
`include "wcb_defines.svh"

module line_buffer (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  // Control from the combining engine
  lb_if.line        lb
);

  wcb_pkg::line_s st_ff;
  wcb_pkg::line_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (lb.clr) begin
      nxt_st.mask = '0;
    end
    if (lb.alloc) begin
      nxt_st.tag  = lb.tag_in;
      nxt_st.mask = '0;
    end
    // Later byte overwrites earlier one in place
    if (lb.wr) begin
      for (int b = 0; b < `WCB_CHUNK_BYTES; b++) begin
        if (lb.be[b]) begin
          nxt_st.data[lb.chunk][b*8 +: 8] = lb.wdata[b*8 +: 8];
          nxt_st.mask[lb.chunk][b]        = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lb.tag   = st_ff.tag;
  assign lb.mask  = st_ff.mask;
  assign lb.rdata = st_ff.data[lb.rd_chunk];
  assign lb.used  = |st_ff.mask;
  assign lb.full  = &st_ff.mask;

endmodule

// *** verilog/write_combining_buffer.sv ***
`include "wcb_defines.svh"

// Notes on behaviour
// - Combining storage is private, apart from caches, and ignores snoops.
// - Repeated writes to one byte keep only the newest value.
// - Several line buffers, each one 64-byte aligned region.
// - Stores allocate lines in round-robin order; a store may fill any open line.
// - Buffered lines may be evicted at any moment by local policy.
// - A completely valid line leaves as one burst write.
// - A line with invalid bytes leaves as 8-byte partial writes.
// - A partial eviction uses at most eight partial writes.
// - Lines need not leave in allocation order.
// - Partial writes of one line may appear in any order.
// - A full line is one atomic burst, any chunk order.
// - Valid bytes of one aligned chunk travel in one transaction.
// - Strong uncacheable stores go out as partial writes.
// - No speculative fetch into uncacheable code or uncacheable branch targets.
// - Uncacheable line may be refetched, or reused for consecutive instructions.
// - Extra fetches only within the current or the following 4-KByte page.
// - Partial lines may wait until a serializing event drains them.
module write_combining_buffer (
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          arst_n_i,
  // Store stream from the core
  input  wire logic                          st_valid_i,
  output      logic                          st_ready_o,
  input  wcb_pkg::mem_type_e                 st_type_i,
  input  wire logic [`WCB_ADDR_W-1:0]        st_addr_i,
  input  wire logic [8*`WCB_CHUNK_BYTES-1:0] st_data_i,
  input  wire logic [`WCB_CHUNK_BYTES-1:0]   st_be_i,
  // Serializing events
  input  wire logic                          serialize_i,
  output      logic                          drain_busy_o,
  // System bus write port
  output      logic                          bus_valid_o,
  input  wire logic                          bus_ready_i,
  output      logic                          bus_burst_o,
  output      logic                          bus_last_o,
  output      logic [`WCB_ADDR_W-1:0]        bus_addr_o,
  output      logic [8*`WCB_CHUNK_BYTES-1:0] bus_data_o,
  output      logic [`WCB_CHUNK_BYTES-1:0]   bus_be_o,
  // Instruction fetch check
  input  wire logic                          fet_req_i,
  input  wire logic                          fet_spec_i,
  input  wcb_pkg::mem_type_e                 fet_type_i,
  input  wire logic [`WCB_ADDR_W-1:0]        fet_addr_i,
  output      logic                          fet_grant_o,
  output      logic                          fet_bus_o,
  input  wire logic [`WCB_ADDR_W-1:0]        fet_extra_addr_i,
  output      logic                          fet_extra_ok_o
);

  localparam int N = `WCB_NUM_LINES;

  wcb_pkg::core_s                st_ff;
  wcb_pkg::core_s                nxt_st;

  logic [N-1:0]                  used;
  logic [N-1:0]                  full;
  logic [N-1:0]                  hit_vec;
  logic [N-1:0]                  wr_vec;
  logic [N-1:0]                  alloc_vec;
  logic [N-1:0]                  clr_vec;
  logic [`WCB_TAG_W-1:0]         tag_q   [N];
  wcb_pkg::mask_t                mask_q  [N];
  logic [8*`WCB_CHUNK_BYTES-1:0] rdata_q [N];

  logic [`WCB_TAG_W-1:0]         st_tag;
  logic [`WCB_CHUNK_W-1:0]       st_chunk;
  logic                          st_uc;
  logic                          st_wc;
  logic [`WCB_IDX_W-1:0]         hit_idx;
  logic [`WCB_IDX_W-1:0]         first_idx;
  logic [`WCB_IDX_W-1:0]         full_idx;
  logic                          any_used;
  logic                          serial;
  logic                          slot_free;
  wcb_pkg::mask_t                ev_mask;
  logic                          found;
  logic [`WCB_CHUNK_W-1:0]       fc;
  logic                          fet_uc;
  logic [`WCB_PAGE_W-1:0]        cur_page;
  logic [`WCB_PAGE_W-1:0]        extra_page;

  assign st_tag   = st_addr_i[`WCB_ADDR_W-1:`WCB_OFS_W];
  assign st_chunk = st_addr_i[`WCB_OFS_W-1:`WCB_CHUNK_W];
  assign st_uc    = st_type_i == wcb_pkg::strong_uncacheable_type;
  assign st_wc    = st_type_i == wcb_pkg::write_combining_type;
  assign any_used = |used;
  assign ev_mask  = mask_q[st_ff.ev_idx];

  // Line storage has no snoop port, so it never answers coherence traffic
  lb_if lbi [N] ();

  for (genvar g = 0; g < N; g++) begin : g_line
    line_buffer u_line (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .lb       (lbi[g])
    );
    assign lbi[g].wr       = wr_vec[g];
    assign lbi[g].alloc    = alloc_vec[g];
    assign lbi[g].clr      = clr_vec[g];
    assign lbi[g].tag_in   = st_tag;
    assign lbi[g].chunk    = st_chunk;
    assign lbi[g].rd_chunk = fc;
    assign lbi[g].wdata    = st_data_i;
    assign lbi[g].be       = st_be_i;
    assign used[g]         = lbi[g].used;
    assign full[g]         = lbi[g].full;
    assign tag_q[g]        = lbi[g].tag;
    assign mask_q[g]       = lbi[g].mask;
    assign rdata_q[g]      = lbi[g].rdata;
    assign hit_vec[g]      = lbi[g].used && (lbi[g].tag == st_tag);
  end

  // Lowest remaining chunk holding valid bytes; ascending order is one legal order
  always_comb begin
    found = 1'b0;
    fc    = '0;
    for (int c = `WCB_CHUNKS - 1; c >= 0; c--) begin
      if (c >= int'(st_ff.chunk) && |ev_mask[c]) begin
        found = 1'b1;
        fc    = 3'(c);
      end
    end
  end

  always_comb begin
    hit_idx   = '0;
    first_idx = '0;
    full_idx  = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = 2'(i);
      end
      if (used[i]) begin
        first_idx = 2'(i);
      end
      if (full[i]) begin
        full_idx = 2'(i);
      end
    end
  end

  assign serial    = st_ff.drain || serialize_i || (st_valid_i && st_uc);
  assign slot_free = !st_ff.o_valid || bus_ready_i;

  always_comb begin
    nxt_st     = st_ff;
    wr_vec     = '0;
    alloc_vec  = '0;
    clr_vec    = '0;
    st_ready_o = 1'b0;
    if (bus_ready_i) begin
      nxt_st.o_valid = 1'b0;
    end
    // Drain request is sticky until every line is empty; a new event wins
    nxt_st.drain = serialize_i || (st_ff.drain && any_used);

    case (st_ff.fsm)
      wcb_pkg::s_idle: begin
        if (serial && any_used) begin
          // Serializing event or uncached access flushes every buffered line first, full or partial
          nxt_st.ev_idx   = first_idx;
          nxt_st.chunk    = '0;
          nxt_st.part_cnt = '0;
          nxt_st.fsm      = full[first_idx] ? wcb_pkg::s_burst : wcb_pkg::s_part;
        end else if (st_valid_i && st_uc) begin
          if (slot_free) begin
            st_ready_o     = 1'b1;
            nxt_st.o_valid = 1'b1;
            nxt_st.o_burst = 1'b0;
            nxt_st.o_last  = 1'b1;
            nxt_st.o_addr  = {st_addr_i[`WCB_ADDR_W-1:`WCB_CHUNK_W], 3'h0};
            nxt_st.o_data  = st_data_i;
            nxt_st.o_be    = st_be_i;
          end
        end else if (|full) begin
          // Full lines leave at once; partial lines wait
          nxt_st.ev_idx   = full_idx;
          nxt_st.chunk    = '0;
          nxt_st.part_cnt = '0;
          nxt_st.fsm      = wcb_pkg::s_burst;
        end else if (st_valid_i && st_wc) begin
          if (|hit_vec) begin
            wr_vec[hit_idx] = 1'b1;
            st_ready_o      = 1'b1;
          end else if (!used[st_ff.alloc_ptr]) begin
            alloc_vec[st_ff.alloc_ptr] = 1'b1;
            wr_vec[st_ff.alloc_ptr]    = 1'b1;
            nxt_st.alloc_ptr           = 2'(st_ff.alloc_ptr + 2'h1);
            st_ready_o                 = 1'b1;
          end else begin
            // Victim is whichever line the pointer reaches, not the oldest written
            nxt_st.ev_idx   = st_ff.alloc_ptr;
            nxt_st.chunk    = '0;
            nxt_st.part_cnt = '0;
            nxt_st.fsm      = full[st_ff.alloc_ptr] ? wcb_pkg::s_burst : wcb_pkg::s_part;
          end
        end else if (st_valid_i) begin
          // Write-back and other types are served by the caches
          st_ready_o = 1'b1;
        end
      end
      wcb_pkg::s_burst, wcb_pkg::s_part: begin
        if (slot_free) begin
          if (found) begin
            nxt_st.o_valid = 1'b1;
            nxt_st.o_addr  = {tag_q[st_ff.ev_idx], fc, 3'h0};
            nxt_st.o_data  = rdata_q[st_ff.ev_idx];
            nxt_st.o_be    = ev_mask[fc];
            nxt_st.chunk   = 4'({1'b0, fc} + 4'h1);
            if (st_ff.fsm == wcb_pkg::s_burst) begin
              nxt_st.o_burst = 1'b1;
              nxt_st.o_last  = fc == 3'h7;
            end else begin
              nxt_st.o_burst  = 1'b0;
              nxt_st.o_last   = 1'b1;
              nxt_st.part_cnt = 4'(st_ff.part_cnt + 4'h1);
            end
          end else begin
            clr_vec[st_ff.ev_idx] = 1'b1;
            nxt_st.fsm            = wcb_pkg::s_idle;
          end
        end
      end
      default: begin
        nxt_st.fsm = wcb_pkg::s_idle;
      end
    endcase

    // Remember the uncacheable line held for decode
    if (fet_grant_o) begin
      if (fet_uc && !fet_spec_i) begin
        nxt_st.code_line   = fet_addr_i[`WCB_ADDR_W-1:`WCB_OFS_W];
        nxt_st.code_line_v = 1'b1;
      end else if (!fet_uc) begin
        nxt_st.code_line_v = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Instruction fetch checks
  assign fet_uc      = fet_type_i == wcb_pkg::strong_uncacheable_type;
  assign fet_grant_o = fet_req_i && !(fet_spec_i && fet_uc);
  assign fet_bus_o   = fet_grant_o && !(fet_uc && st_ff.code_line_v
                       && st_ff.code_line == fet_addr_i[`WCB_ADDR_W-1:`WCB_OFS_W]);
  assign cur_page    = st_ff.code_line[`WCB_TAG_W-1:`WCB_PAGE_SHIFT-`WCB_OFS_W];
  assign extra_page  = fet_extra_addr_i[`WCB_ADDR_W-1:`WCB_PAGE_SHIFT];
  assign fet_extra_ok_o = st_ff.code_line_v && (extra_page == cur_page ||
                          extra_page == 20'(cur_page + 20'h1));

  assign drain_busy_o = st_ff.drain;
  assign bus_valid_o  = st_ff.o_valid;
  assign bus_burst_o  = st_ff.o_burst;
  assign bus_last_o   = st_ff.o_last;
  assign bus_addr_o   = st_ff.o_addr;
  assign bus_data_o   = st_ff.o_data;
  assign bus_be_o     = st_ff.o_be;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_burst_full_be: assert property (bus_valid_o && bus_burst_o |-> bus_be_o == `WCB_FULL_BE)
    else $error("burst beat without all bytes valid");

  a_burst_beats_back: assert property (bus_valid_o && bus_burst_o && !bus_last_o && bus_ready_i
    |=> bus_valid_o && bus_burst_o
        && bus_addr_o[5:3] == 3'($past(bus_addr_o[5:3]) + 3'h1))
    else $error("burst interrupted or chunk skipped");

  a_partial_single: assert property (bus_valid_o && !bus_burst_o |-> bus_last_o && bus_be_o != 8'h00)
    else $error("partial write not a single nonempty beat");

  a_partial_count: assert property (st_ff.part_cnt <= `WCB_MAX_PARTIALS)
    else $error("too many partial writes for one line");

  a_chunk_whole: assert property (bus_valid_o && !bus_burst_o && st_ff.fsm == wcb_pkg::s_part
    |-> bus_be_o == ev_mask[bus_addr_o[5:3]])
    else $error("chunk split across transactions");

  a_uc_partial: assert property (st_valid_i && st_ready_o && st_uc
    |=> bus_valid_o && !bus_burst_o && bus_data_o == $past(st_data_i))
    else $error("uncacheable store not issued as partial write");

  a_uc_after_drain: assert property (st_valid_i && st_ready_o && st_uc |-> !any_used)
    else $error("uncached store passed buffered lines");

  a_drain_follow: assert property (serialize_i |=> drain_busy_o)
    else $error("serializing event not seen");

  a_spec_uc_fetch: assert property (fet_req_i && fet_spec_i && fet_uc |-> !fet_grant_o)
    else $error("speculative fetch into uncacheable code");

  a_line_cleared: assert property (st_ff.fsm != wcb_pkg::s_idle && nxt_st.fsm == wcb_pkg::s_idle
    |=> !used[$past(st_ff.ev_idx)])
    else $error("evicted line kept valid bytes");

  a_alloc_onehot: assert property ($onehot0(alloc_vec))
    else $error("more than one line allocated at once");

  a_alloc_empty: assert property (|alloc_vec |-> (alloc_vec & used) == '0)
    else $error("allocation into a line that holds data");

  a_burst_full: assert property (st_ff.fsm == wcb_pkg::s_burst |-> full[st_ff.ev_idx])
    else $error("burst started from a line with invalid bytes");

  a_part_open: assert property (st_ff.fsm == wcb_pkg::s_part |-> !full[st_ff.ev_idx])
    else $error("full line sent as partial writes");

  a_burst_single: assert property (bus_burst_o && bus_last_o && bus_ready_i
    && bus_valid_o |=> !bus_valid_o)
    else $error("burst continued past its last beat");

  a_beat_hold: assert property (bus_valid_o && !bus_ready_i |=> bus_valid_o
    && $stable(bus_addr_o) && $stable(bus_data_o) && $stable(bus_be_o))
    else $error("stalled beat changed before it was taken");

  a_nonspec_grant: assert property (fet_req_i && !fet_spec_i |-> fet_grant_o)
    else $error("non-speculative fetch refused");

  a_code_reuse: assert property (fet_grant_o && fet_uc && !fet_spec_i
    ##1 fet_req_i && fet_uc && fet_addr_i[31:6] == $past(fet_addr_i[31:6]) |-> !fet_bus_o)
    else $error("held uncacheable line fetched again");

  a_extra_near: assert property (fet_extra_ok_o |-> st_ff.code_line_v
    && 20'(extra_page - cur_page) <= 20'h1)
    else $error("extra line beyond the following page");

  a_drain_release: assert property (drain_busy_o && !any_used && !serialize_i
    |=> !drain_busy_o)
    else $error("drain flag stuck after lines emptied");

  a_evict_used: assert property (st_ff.fsm != wcb_pkg::s_idle |-> used[st_ff.ev_idx])
    else $error("eviction of an empty line");

endmodule

// *** sim/mem_agent.sv ***
`include "wcb_defines.svh"

module mem_agent (
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          arst_n_i,
  // Bus write port from the buffer
  input  wire logic                          bus_valid_i,
  output      logic                          bus_ready_o,
  input  wire logic                          bus_burst_i,
  input  wire logic                          bus_last_i,
  input  wire logic [`WCB_ADDR_W-1:0]        bus_addr_i,
  input  wire logic [8*`WCB_CHUNK_BYTES-1:0] bus_data_i,
  input  wire logic [`WCB_CHUNK_BYTES-1:0]   bus_be_i,
  // Stall control
  input  wire logic                          slow_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`WCB_ADDR_W-1:0]        log_addr[$];
  logic [8*`WCB_CHUNK_BYTES-1:0] log_data[$];
  logic [`WCB_CHUNK_BYTES-1:0]   log_be[$];
  logic                          log_burst[$];
  logic                          log_last[$];
  logic [1:0]                    stall_cnt;

  // Beats logged in arrival order, whatever line they belong to
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_ready_o <= 1'b0;
      stall_cnt <= 2'h0;
    end else begin
      if (bus_valid_i && bus_ready_o) begin
        log_addr.push_back(bus_addr_i);
        log_data.push_back(bus_data_i);
        log_be.push_back(bus_be_i);
        log_burst.push_back(bus_burst_i);
        log_last.push_back(bus_last_i);
      end
      stall_cnt <= stall_cnt + 2'h1;
      // Slow mode accepts one cycle in four
      bus_ready_o <= !slow_i || (stall_cnt == 2'h3);
    end
  end
endmodule

// *** sim/tb_write_combining_buffer.sv ***
`include "wcb_defines.svh"

`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR at %0t: got 0x%0h expected 0x%0h", $time, (got), (exp)); \
    end \
  end

module tb_write_combining_buffer;
  timeunit 1ns;
  timeprecision 1ps;

  logic               mclk_i;
  logic               arst_n_i;
  logic               st_valid_i;
  logic               st_ready_o;
  wcb_pkg::mem_type_e st_type_i;
  logic [31:0]        st_addr_i;
  logic [63:0]        st_data_i;
  logic [7:0]         st_be_i;
  logic               serialize_i;
  logic               drain_busy_o;
  logic               bus_valid_o;
  logic               bus_ready_i;
  logic               bus_burst_o;
  logic               bus_last_o;
  logic [31:0]        bus_addr_o;
  logic [63:0]        bus_data_o;
  logic [7:0]         bus_be_o;
  logic               fet_req_i;
  logic               fet_spec_i;
  wcb_pkg::mem_type_e fet_type_i;
  logic [31:0]        fet_addr_i;
  logic               fet_grant_o;
  logic               fet_bus_o;
  logic [31:0]        fet_extra_addr_i;
  logic               fet_extra_ok_o;
  logic               slow_i;
  int                 mismatches;
  int                 checks;
  int                 cyc;
  int                 base;

  write_combining_buffer dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .st_valid_i(st_valid_i),
    .st_ready_o(st_ready_o), .st_type_i(st_type_i), .st_addr_i(st_addr_i),
    .st_data_i(st_data_i), .st_be_i(st_be_i), .serialize_i(serialize_i),
    .drain_busy_o(drain_busy_o), .bus_valid_o(bus_valid_o), .bus_ready_i(bus_ready_i),
    .bus_burst_o(bus_burst_o), .bus_last_o(bus_last_o), .bus_addr_o(bus_addr_o),
    .bus_data_o(bus_data_o), .bus_be_o(bus_be_o), .fet_req_i(fet_req_i),
    .fet_spec_i(fet_spec_i), .fet_type_i(fet_type_i), .fet_addr_i(fet_addr_i),
    .fet_grant_o(fet_grant_o), .fet_bus_o(fet_bus_o), .fet_extra_addr_i(fet_extra_addr_i),
    .fet_extra_ok_o(fet_extra_ok_o));

  mem_agent mem_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_valid_i(bus_valid_o),
    .bus_ready_o(bus_ready_i), .bus_burst_i(bus_burst_o), .bus_last_i(bus_last_o),
    .bus_addr_i(bus_addr_o), .bus_data_i(bus_data_o), .bus_be_i(bus_be_o), .slow_i(slow_i));

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [63:0] bmask(input logic [7:0] b);
    logic [63:0] m;
    for (int i = 0; i < 8; i++) begin
      m[8*i+:8] = {8{b[i]}};
    end
    return m;
  endfunction

  function automatic int find(input logic [31:0] a);
    for (int i = base; i < mem_u.log_addr.size(); i++) begin
      if (mem_u.log_addr[i] === a) begin
        return i;
      end
    end
    return mem_u.log_addr.size();
  endfunction

  // Request held until taken; valid left high for back-to-back stores
  task automatic store(input wcb_pkg::mem_type_e t, input logic [31:0] a,
                       input logic [63:0] d, input logic [7:0] b);
    int n;
    n = 0;
    st_valid_i <= 1'b1;
    st_type_i <= t;
    st_addr_i <= a;
    st_data_i <= d;
    st_be_i <= b;
    @(negedge mclk_i);
    while (st_ready_o !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    `CHK(st_ready_o, 1'b1)
    @(posedge mclk_i);
  endtask

  task automatic expect_beats(input int k);
    int n;
    n = 0;
    while (mem_u.log_addr.size() < base + k && n < 400) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (20) @(posedge mclk_i);
    `CHK(mem_u.log_addr.size(), base + k)
  endtask

  task automatic chk_beat(input int i, input logic [31:0] a, input logic [63:0] d,
                          input logic [7:0] b, input logic bu);
    `CHK(mem_u.log_addr[i], a)
    `CHK(mem_u.log_be[i], b)
    `CHK(mem_u.log_data[i] & bmask(b), d & bmask(b))
    `CHK(mem_u.log_burst[i], bu)
    `CHK(mem_u.log_last[i], logic'(!bu || a[5:3] == 3'h7))
  endtask

  task automatic t_full_burst();
    base = mem_u.log_addr.size();
    slow_i <= 1'b1;
    store(wcb_pkg::write_combining_type, 32'h1000, 64'hDEAD_BEEF_DEAD_BEEF, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      store(wcb_pkg::write_combining_type, 32'h1000 + 32'(8*c), {8{8'h10 + 8'(c)}}, 8'hFF);
    end
    st_valid_i <= 1'b0;
    expect_beats(8);
    for (int c = 0; c < 8; c++) begin
      chk_beat(base + c, 32'h1000 + 32'(8*c), {8{8'h10 + 8'(c)}}, 8'hFF, 1'b1);
    end
    slow_i <= 1'b0;
    $display("test full_burst done");
  endtask

  task automatic t_partial_drain();
    base = mem_u.log_addr.size();
    store(wcb_pkg::write_combining_type, 32'h2008, 64'h0000_0000_1111_1111, 8'h0F);
    store(wcb_pkg::write_combining_type, 32'h2008, 64'h2222_2222_0000_0000, 8'hF0);
    store(wcb_pkg::write_combining_type, 32'h2018, 64'h0000_0000_0000_0033, 8'h01);
    st_valid_i <= 1'b0;
    repeat (30) @(posedge mclk_i);
    `CHK(mem_u.log_addr.size(), base)
    store(wcb_pkg::write_combining_type, 32'h2040, 64'h4400_0000_0000_0000, 8'h80);
    st_valid_i <= 1'b0;
    // Explicit drain before the data is relied on
    serialize_i <= 1'b1;
    @(posedge mclk_i);
    serialize_i <= 1'b0;
    @(negedge mclk_i);
    `CHK(drain_busy_o, 1'b1)
    expect_beats(3);
    chk_beat(find(32'h2008), 32'h2008, 64'h2222_2222_1111_1111, 8'hFF, 1'b0);
    chk_beat(find(32'h2018), 32'h2018, 64'h0000_0000_0000_0033, 8'h01, 1'b0);
    chk_beat(find(32'h2040), 32'h2040, 64'h4400_0000_0000_0000, 8'h80, 1'b0);
    `CHK(drain_busy_o, 1'b0)
    $display("test partial_drain done");
  endtask

  task automatic t_uncached();
    base = mem_u.log_addr.size();
    store(wcb_pkg::write_back_type, 32'h3000, 64'h0000_0000_0000_0055, 8'hFF);
    store(wcb_pkg::other_type, 32'h3010, 64'h0000_0000_0000_0066, 8'hFF);
    store(wcb_pkg::strong_uncacheable_type, 32'h3008, 64'h0123_4567_89AB_CDEF, 8'hFF);
    st_valid_i <= 1'b0;
    expect_beats(1);
    chk_beat(base, 32'h3008, 64'h0123_4567_89AB_CDEF, 8'hFF, 1'b0);
    $display("test uncached done");
  endtask

  // Fifth line forces the round-robin victim out before any serializing event
  task automatic t_pressure();
    base = mem_u.log_addr.size();
    for (int i = 0; i < 5; i++) begin
      store(wcb_pkg::write_combining_type, 32'h4000 + 32'(64*i), 64'(i + 1), 8'h01);
    end
    st_valid_i <= 1'b0;
    expect_beats(1);
    chk_beat(base, 32'h4000, 64'h1, 8'h01, 1'b0);
    base = base + 1;
    serialize_i <= 1'b1;
    @(posedge mclk_i);
    serialize_i <= 1'b0;
    expect_beats(4);
    chk_beat(find(32'h4100), 32'h4100, 64'h5, 8'h01, 1'b0);
    $display("test pressure done");
  endtask

  // Side-effect I/O kept away from the code page and the one after
  task automatic fetch(input logic spec, input wcb_pkg::mem_type_e t, input logic [31:0] a,
                       input logic [31:0] x);
    @(posedge mclk_i);
    fet_req_i <= 1'b1;
    fet_spec_i <= spec;
    fet_type_i <= t;
    fet_addr_i <= a;
    fet_extra_addr_i <= x;
    @(negedge mclk_i);
  endtask

  task automatic t_fetch();
    fetch(1'b1, wcb_pkg::strong_uncacheable_type, 32'h5000, 32'h5000);
    `CHK(fet_grant_o, 1'b0)
    `CHK(fet_extra_ok_o, 1'b0)
    fetch(1'b0, wcb_pkg::strong_uncacheable_type, 32'h5000, 32'h6000);
    `CHK(fet_grant_o, 1'b1)
    `CHK(fet_bus_o, 1'b1)
    fetch(1'b0, wcb_pkg::strong_uncacheable_type, 32'h5008, 32'h6040);
    `CHK(fet_bus_o, 1'b0)
    `CHK(fet_extra_ok_o, 1'b1)
    fetch(1'b0, wcb_pkg::strong_uncacheable_type, 32'h5008, 32'h7000);
    `CHK(fet_extra_ok_o, 1'b0)
    fetch(1'b1, wcb_pkg::write_back_type, 32'h8000, 32'h4000);
    `CHK(fet_grant_o, 1'b1)
    `CHK(fet_extra_ok_o, 1'b0)
    @(posedge mclk_i);
    fet_req_i <= 1'b0;
    $display("test fetch done");
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    arst_n_i = 1'b0;
    st_valid_i = 1'b0;
    st_type_i = wcb_pkg::write_back_type;
    st_addr_i = 32'h0;
    st_data_i = 64'h0;
    st_be_i = 8'h0;
    serialize_i = 1'b0;
    fet_req_i = 1'b0;
    fet_spec_i = 1'b0;
    fet_type_i = wcb_pkg::write_back_type;
    fet_addr_i = 32'h0;
    fet_extra_addr_i = 32'h0;
    slow_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_full_burst();
    t_partial_drain();
    t_uncached();
    t_pressure();
    t_fetch();
    test_done();
  end
endmodule
